// ===== dv/isd_dmem_model.sv
// Purpose: behavioural data memory facing the decoder core
// Assumes: reads answer in the same cycle, writes land on the edge
// Notes: only the low address byte is decoded, higher pages alias
`timescale 1ns/100ps
module isd_dmem_model (
  // clock
  input wire logic clk_in,
  // read side
  input wire logic [15:0] addr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // write side
  input wire logic wr_in,
  input wire logic [15:0] waddr_in,
  input wire logic [7:0] wdata_in
);
  logic [7:0] mem [256];
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // each byte holds its own address so reads are easy to predict
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0];
    end
  end
  // unselected reads show the inverse, so a stray sample never matches
  assign rdata_out = rd_in ? mem[addr_in[7:0]] : ~mem[addr_in[7:0]];
  // write lands on the edge
  always @(posedge clk_in) begin
    if (wr_in) begin
      mem[waddr_in[7:0]] <= wdata_in;
    end
  end
endmodule : isd_dmem_model

// ===== dv/tb.sv
// Purpose: self-checking bench for the instruction decoder core
// Assumes: data memory model answers reads in the same cycle
// Notes: a row is {op, expected W, flags zero carry digit-carry}
`timescale 1ns/100ps
module tb;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [13:0] instr_in = 14'h0000;
  logic instr_valid_in = 1'b0;
  logic [6:0] pclath_in = 7'h00;
  logic [7:0] rdata, wdata, w, opt;
  logic rdy, mrd, mwr, c, dcy, z, tmo, pwd, wdc, stby, srst, iret;
  logic [15:0] maddr, waddr, fp0, fp1;
  logic [14:0] pc;
  logic [63:0] pdir;
  int mismatches = 0;
  int n_compared = 0;
  logic [27:0] rows [8] = '{28'h3EF0F00, 28'h3E1F0F2, 28'h3E01101, 28'h3EF0006,
    28'h393C006, 28'h3EFFFF0, 28'h3903030, 28'h0000030};
  // ----------------------------------------------------------------
  // clock, core and memory
  // ----------------------------------------------------------------
  always #50 clk_in = ~clk_in;
  isd_core u_isd_core (.clk_in(clk_in), .arst_n_in(arst_n_in), .instr_in(instr_in),
    .instr_valid_in(instr_valid_in), .instr_ready_out(rdy), .pclath_in(pclath_in), .mem_addr_out(maddr),
    .mem_rd_out(mrd), .mem_rdata_in(rdata), .mem_wr_out(mwr), .mem_waddr_out(waddr), .mem_wdata_out(wdata),
    .pc_out(pc), .w_out(w), .carry_out(c), .digit_carry_flag_out(dcy), .zero_out(z), .timeout_flag_out(tmo),
    .powerdown_flag_out(pwd), .option_out(opt), .pin_direction_reg_out(pdir), .file_pointer0_out(fp0),
    .file_pointer1_out(fp1), .watchdog_clear_out(wdc), .standby_out(stby), .soft_reset_out(srst),
    .interrupt_return_out(iret));
  isd_dmem_model u_isd_dmem_model (.clk_in(clk_in), .addr_in(maddr), .rd_in(mrd), .rdata_out(rdata),
    .wr_in(mwr), .waddr_in(waddr), .wdata_in(wdata));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // hold the word until a ready edge takes it, then stop at mid-cycle after
  task ex(input logic [13:0] op);
    int n;
    n = 0;
    @(posedge clk_in);
    instr_in <= op;
    instr_valid_in <= 1'b1;
    @(negedge clk_in);
    while (rdy !== 1'b1 && n < 4) begin
      @(negedge clk_in);
      n++;
    end
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    @(negedge clk_in);
  endtask : ex
  task end_sim;
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  // the whole run is about 90 cycles, so 400 leaves ample margin
  initial begin
    #40000;
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(negedge clk_in);
    chk({pc, w, tmo, pwd, opt, rdy}, {15'h0000, 8'h00, 2'h3, 8'hFF, 1'b1});
    foreach (rows[i]) begin
      ex(rows[i][25:12]);
      chk({w, z, c, dcy}, {rows[i][11:4], rows[i][2:0]});
    end
    ex(14'h0062);
    chk(opt, 8'h03);
    ex(14'h0065);
    chk(pdir[47:40], 8'h03);
    ex(14'h0063);
    chk({stby, tmo, pwd}, 3'b110);
    ex(14'h0064);
    chk({wdc, tmo, pwd}, 3'b111);
    ex(14'h2810);
    chk({pc, rdy}, {15'h0010, 1'b0});
    ex(14'h3205);
    chk(pc, 15'h0016);
    ex(14'h33FF);
    chk(pc, 15'h0016);
    ex(14'h2100);
    chk(pc, 15'h0100);
    ex(14'h0008);
    chk(pc, 15'h0017);
    ex(14'h0009);
    chk(iret, 1'b1);
    ex(14'h3455);
    chk({w, rdy}, {8'h55, 1'b0});
    ex(14'h313F);
    chk(fp0, 16'hFFFF);
    ex(14'h311F);
    chk({fp0, z, c, dcy}, {16'h001E, 3'b000});
    ex(14'h3145);
    chk(fp1, 16'h0005);
    ex(14'h001C);
    chk({mwr, waddr, wdata, fp1}, {1'b1, 16'h0006, 8'h55, 16'h0006});
    ex(14'h3900);
    ex(14'h0016);
    chk({w, z, fp1}, {8'h55, 1'b0, 16'h0007});
    ex(14'h3900);
    ex(14'h3F7F);
    chk({w, z, fp1}, {8'h55, 1'b0, 16'h0007});
    ex(14'h3FC1);
    chk({mwr, waddr, wdata}, {1'b1, 16'h0008, 8'h55});
    ex(14'h3120);
    ex(14'h0010);
    chk({rdy, w, fp0}, {1'b0, 8'hFF, 16'hFFFF});
    ex(14'h0540);
    chk({w, z}, {8'h40, 1'b0});
    ex(14'h05C0);
    chk({mwr, waddr, wdata}, {1'b1, 16'h0040, 8'h40});
    ex(14'h0001);
    chk({srst, w, fp0, opt}, {1'b1, 8'h00, 16'h0000, 8'hFF});
    // jumps through W and a page-select value with all bits in use
    ex(14'h3E07);
    ex(14'h000B);
    chk({pc, rdy}, {15'h0009, 1'b0});
    @(posedge clk_in);
    pclath_in <= 7'h4D;
    ex(14'h000A);
    chk({pc, rdy}, {15'h4D07, 1'b0});
    ex(14'h0008);
    chk(pc, 15'h000A);
    ex(14'h2803);
    chk(pc, 15'h4803);
    // the two decrement modes, and the window read through pointer 1
    ex(14'h001D);
    chk({mwr, waddr, wdata, fp1}, {1'b1, 16'hFFFF, 8'h07, 16'hFFFF});
    ex(14'h0501);
    chk({rdy, w, z}, {1'b0, 8'h07, 1'b0});
    ex(14'h0013);
    chk({w, z, fp0}, {8'h00, 1'b1, 16'hFFFF});
    // hardware reset in mid-run restores the same state
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(negedge clk_in);
    chk({pc, z, fp0, fp1, rdy}, {15'h0000, 1'b0, 32'h0000_0000, 1'b1});
    end_sim();
  end
endmodule : tb

// ===== src/isd_core.sv
// Purpose: decodes and executes control, inherent, pointer and literal instructions
// Assumes: memory read data answers combinationally to mem_addr_out in the same cycle
// Notes: a new instruction is taken only while instr_ready_out is high
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module isd_core #(
  parameter int STACK_DEPTH = isd_pkg::STACK_DEPTH_DEF
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // instruction stream
  input wire logic [13:0] instr_in,
  input wire logic instr_valid_in,
  output logic instr_ready_out,
  input wire logic [6:0] pclath_in,
  // data memory
  output logic [15:0] mem_addr_out,
  output logic mem_rd_out,
  input wire logic [7:0] mem_rdata_in,
  output logic mem_wr_out,
  output logic [15:0] mem_waddr_out,
  output logic [7:0] mem_wdata_out,
  // core state
  output logic [14:0] pc_out,
  output logic [7:0] w_out,
  output logic carry_out,
  output logic digit_carry_flag_out,
  output logic zero_out,
  output logic timeout_flag_out,
  output logic powerdown_flag_out,
  output logic [7:0] option_out,
  output logic [63:0] pin_direction_reg_out,
  output logic [15:0] file_pointer0_out,
  output logic [15:0] file_pointer1_out,
  // event pulses
  output logic watchdog_clear_out,
  output logic standby_out,
  output logic soft_reset_out,
  output logic interrupt_return_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int SP_W = $clog2(STACK_DEPTH);

  // refuse at elaboration a stack the wrapping pointer cannot serve
  if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_depth_check
    $error("isd_core: STACK_DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    isd_pkg::isd_phase_t phase;
    logic [14:0] pc;
    logic [7:0] w;
    logic c;
    logic dig_cy;
    logic z;
    logic timeout_flag;
    logic powerdown_flag;
    logic [7:0] option;
    logic [7:0][7:0] pin_dir;
    logic [15:0] fp0;
    logic [15:0] fp1;
    logic [STACK_DEPTH-1:0][14:0] stack;
    logic [SP_W-1:0] sp;
    logic mem_wr;
    logic [15:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic wdt_clr;
    logic standby;
    logic soft_rst;
    logic int_ret;
  } isd_state_t;

  localparam isd_state_t ST_RST = '{
    phase: isd_pkg::PH_EXEC,
    w: isd_pkg::W_RST,
    timeout_flag: isd_pkg::TIMEOUT_RST,
    powerdown_flag: isd_pkg::POWERDOWN_RST,
    option: isd_pkg::OPTION_RST,
    pin_dir: {8{isd_pkg::PIN_DIR_RST}},
    default: '0
  };

  isd_state_t st;
  isd_state_t nx;

  function automatic logic op_hit(input logic [13:0] word, input logic [13:0] mask, input logic [13:0] val);
    return (word & mask) == val;
  endfunction : op_hit

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic exec;
  logic dec_rel_jump, dec_jump_by_w, dec_call, dec_abs_jump, dec_call_by_w;
  logic dec_int_ret, dec_return, dec_ret_lit, dec_wdt, dec_idle, dec_option;
  logic dec_soft_rst, dec_standby, dec_pin_dir, dec_ptr_add, dec_load, dec_store;
  logic dec_load_idx, dec_store_idx, dec_lit_and, dec_lit_add, dec_and_file, dec_ctrl;

  assign exec = instr_valid_in && (st.phase == isd_pkg::PH_EXEC);
  assign dec_rel_jump = op_hit(instr_in, isd_pkg::MASK_TOP5, isd_pkg::OP_REL_JUMP);
  assign dec_jump_by_w = op_hit(instr_in, isd_pkg::MASK_FULL, isd_pkg::OP_JUMP_BY_W);
  assign dec_call = op_hit(instr_in, isd_pkg::MASK_TOP3, isd_pkg::OP_CALL);
  assign dec_abs_jump = op_hit(instr_in, isd_pkg::MASK_TOP3, isd_pkg::OP_ABS_JUMP);
  assign dec_call_by_w = op_hit(instr_in, isd_pkg::MASK_FULL, isd_pkg::OP_CALL_BY_W);
  assign dec_int_ret = op_hit(instr_in, isd_pkg::MASK_FULL, isd_pkg::OP_INT_RETURN);
  assign dec_return = op_hit(instr_in, isd_pkg::MASK_FULL, isd_pkg::OP_RETURN);
  assign dec_ret_lit = op_hit(instr_in, isd_pkg::MASK_TOP6, isd_pkg::OP_RET_LIT);
  assign dec_wdt = op_hit(instr_in, isd_pkg::MASK_FULL, isd_pkg::OP_WDT_CLEAR);
  assign dec_standby = op_hit(instr_in, isd_pkg::MASK_FULL, isd_pkg::OP_STANDBY);
  assign dec_idle = op_hit(instr_in, isd_pkg::MASK_FULL, isd_pkg::OP_IDLE);
  assign dec_soft_rst = op_hit(instr_in, isd_pkg::MASK_FULL, isd_pkg::OP_SOFT_RESET);
  assign dec_option = op_hit(instr_in, isd_pkg::MASK_FULL, isd_pkg::OP_OPTION_LOAD);
  // option, standby and watchdog words share this range, so they take priority
  assign dec_pin_dir = op_hit(instr_in, isd_pkg::MASK_LOW3, isd_pkg::OP_PIN_DIR)
                       && !dec_option && !dec_standby && !dec_wdt;
  assign dec_ptr_add = op_hit(instr_in, isd_pkg::MASK_TOP7, isd_pkg::OP_PTR_ADD);
  assign dec_load = op_hit(instr_in, isd_pkg::MASK_LOW3, isd_pkg::OP_PTR_LOAD);
  assign dec_load_idx = op_hit(instr_in, isd_pkg::MASK_TOP7, isd_pkg::OP_PTR_LOAD_IDX);
  assign dec_store = op_hit(instr_in, isd_pkg::MASK_LOW3, isd_pkg::OP_PTR_STORE);
  assign dec_store_idx = op_hit(instr_in, isd_pkg::MASK_TOP7, isd_pkg::OP_PTR_STORE_IDX);
  assign dec_lit_and = op_hit(instr_in, isd_pkg::MASK_TOP6, isd_pkg::OP_LIT_AND);
  // six top bits: five would also catch the indexed pointer moves
  assign dec_lit_add = op_hit(instr_in, isd_pkg::MASK_TOP6, isd_pkg::OP_LIT_ADD);
  assign dec_and_file = op_hit(instr_in, isd_pkg::MASK_TOP6, isd_pkg::OP_AND_FILE);
  assign dec_ctrl = dec_rel_jump | dec_jump_by_w | dec_call | dec_abs_jump | dec_call_by_w
                    | dec_int_ret | dec_return | dec_ret_lit;

  // ----------------------------------------------------------------
  // datapath helpers
  // ----------------------------------------------------------------
  logic sel_n;
  logic [15:0] fp_sel, fp_step, ptr_upd, sext6, idx_addr, ptr_add_res, file_fp;
  logic [14:0] pc_inc, sext9, top_of_stack;
  logic [8:0] add_sum;
  logic [4:0] add_low;
  logic [7:0] and_lit, and_file;
  logic file_ind;
  logic pre_mode;
  logic ind_msb;

  // pointer select bit sits in a different place for moded and indexed forms
  assign sel_n = (dec_load | dec_store) ? instr_in[isd_pkg::POS_N_MODE] : instr_in[isd_pkg::POS_N_IMM];
  assign fp_sel = sel_n ? st.fp1 : st.fp0;
  assign fp_step = instr_in[0] ? 16'hFFFF : 16'h0001;
  assign ptr_upd = fp_sel + fp_step;
  assign pre_mode = (instr_in[1:0] == isd_pkg::UPD_PRE_INC) || (instr_in[1:0] == isd_pkg::UPD_PRE_DEC);
  assign sext6 = {{10{instr_in[5]}}, instr_in[5:0]};
  assign idx_addr = fp_sel + sext6;
  assign ptr_add_res = fp_sel + sext6;
  assign pc_inc = st.pc + 15'h0001;
  assign sext9 = {{6{instr_in[8]}}, instr_in[8:0]};
  assign top_of_stack = st.stack[st.sp - 1'b1];
  assign add_sum = {1'b0, st.w} + {1'b0, instr_in[7:0]};
  assign add_low = {1'b0, st.w[3:0]} + {1'b0, instr_in[3:0]};
  assign and_lit = st.w & instr_in[7:0];
  assign and_file = st.w & mem_rdata_in;
  assign file_ind = (instr_in[6:0] == isd_pkg::ADDR_IND_WIN0) || (instr_in[6:0] == isd_pkg::ADDR_IND_WIN1);
  assign file_fp = instr_in[0] ? st.fp1 : st.fp0;

  // memory address; read data must come back in the same cycle
  always_comb begin
    mem_addr_out = 16'h0000;
    ind_msb = 1'b0;
    if (dec_load || dec_store) begin
      mem_addr_out = pre_mode ? ptr_upd : fp_sel;
      ind_msb = fp_sel[15];
    end else if (dec_load_idx || dec_store_idx) begin
      mem_addr_out = idx_addr;
      ind_msb = fp_sel[15];
    end else if (dec_and_file) begin
      mem_addr_out = file_ind ? file_fp : {9'h000, instr_in[6:0]};
      ind_msb = file_ind && file_fp[15];
    end
  end

  assign mem_rd_out = exec && (dec_load || dec_load_idx || dec_and_file);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nx = st;
    nx.mem_wr = 1'b0;
    nx.wdt_clr = 1'b0;
    nx.standby = 1'b0;
    nx.soft_rst = 1'b0;
    nx.int_ret = 1'b0;
    case (st.phase)
      isd_pkg::PH_FLUSH, isd_pkg::PH_EXTRA: begin
        nx.phase = isd_pkg::PH_EXEC;
      end
      isd_pkg::PH_EXEC: begin
        if (instr_valid_in) begin
          nx.pc = pc_inc;
          if (dec_rel_jump) begin
            nx.pc = pc_inc + sext9;
          end else if (dec_jump_by_w) begin
            nx.pc = pc_inc + {7'h00, st.w};
          end else if (dec_call || dec_call_by_w) begin
            nx.stack[st.sp] = pc_inc;
            nx.sp = st.sp + 1'b1;
            nx.pc = dec_call ? {pclath_in[6:3], instr_in[10:0]} : {pclath_in, st.w};
          end else if (dec_abs_jump) begin
            nx.pc = {pclath_in[6:3], instr_in[10:0]};
          end else if (dec_int_ret || dec_return || dec_ret_lit) begin
            nx.sp = st.sp - 1'b1;
            nx.pc = top_of_stack;
            nx.int_ret = dec_int_ret;
            if (dec_ret_lit) begin
              nx.w = instr_in[7:0];
            end
          end else if (dec_wdt) begin
            nx.wdt_clr = 1'b1;
            nx.timeout_flag = 1'b1;
            nx.powerdown_flag = 1'b1;
          end else if (dec_standby) begin
            nx.standby = 1'b1;
            nx.timeout_flag = 1'b1;
            nx.powerdown_flag = 1'b0;
          end else if (dec_soft_rst) begin
            nx = ST_RST;
            nx.soft_rst = 1'b1;
          end else if (dec_option) begin
            nx.option = st.w;
          end else if (dec_pin_dir) begin
            nx.pin_dir[instr_in[2:0]] = st.w;
          end else if (dec_ptr_add) begin
            if (sel_n) begin
              nx.fp1 = ptr_add_res;
            end else begin
              nx.fp0 = ptr_add_res;
            end
          end else if (dec_load || dec_store) begin
            if (sel_n) begin
              nx.fp1 = ptr_upd;
            end else begin
              nx.fp0 = ptr_upd;
            end
            if (dec_load) begin
              nx.w = mem_rdata_in;
              nx.z = (mem_rdata_in == 8'h00);
            end else begin
              nx.mem_wr = 1'b1;
              nx.mem_waddr = mem_addr_out;
              nx.mem_wdata = st.w;
            end
          end else if (dec_load_idx) begin
            nx.w = mem_rdata_in;
            nx.z = (mem_rdata_in == 8'h00);
          end else if (dec_store_idx) begin
            nx.mem_wr = 1'b1;
            nx.mem_waddr = mem_addr_out;
            nx.mem_wdata = st.w;
          end else if (dec_lit_and) begin
            nx.w = and_lit;
            nx.z = (and_lit == 8'h00);
          end else if (dec_lit_add) begin
            nx.w = add_sum[7:0];
            nx.c = add_sum[8];
            nx.dig_cy = add_low[4];
            nx.z = (add_sum[7:0] == 8'h00);
          end else if (dec_and_file) begin
            nx.z = (and_file == 8'h00);
            if (instr_in[isd_pkg::POS_DEST]) begin
              nx.mem_wr = 1'b1;
              nx.mem_waddr = mem_addr_out;
              nx.mem_wdata = and_file;
            end else begin
              nx.w = and_file;
            end
          end
          // unknown words fall through as plain idle steps
          if (dec_ctrl) begin
            nx.phase = isd_pkg::PH_FLUSH;
          end else if (ind_msb && !dec_soft_rst) begin
            nx.phase = isd_pkg::PH_EXTRA;
          end
        end
      end
      default: begin
        nx.phase = isd_pkg::PH_EXEC;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= ST_RST;
    end else begin
      st <= nx;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign instr_ready_out = (st.phase == isd_pkg::PH_EXEC);
  assign mem_wr_out = st.mem_wr;
  assign mem_waddr_out = st.mem_waddr;
  assign mem_wdata_out = st.mem_wdata;
  assign pc_out = st.pc;
  assign w_out = st.w;
  assign carry_out = st.c;
  assign digit_carry_flag_out = st.dig_cy;
  assign zero_out = st.z;
  assign timeout_flag_out = st.timeout_flag;
  assign powerdown_flag_out = st.powerdown_flag;
  assign option_out = st.option;
  assign pin_direction_reg_out = st.pin_dir;
  assign file_pointer0_out = st.fp0;
  assign file_pointer1_out = st.fp1;
  assign watchdog_clear_out = st.wdt_clr;
  assign standby_out = st.standby;
  assign soft_reset_out = st.soft_rst;
  assign interrupt_return_out = st.int_ret;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence s_one_stall;
    !instr_ready_out ##1 instr_ready_out;
  endsequence

  property p_ctrl_two_cycles;
    exec && dec_ctrl |=> s_one_stall;
  endproperty
  a_ctrl_two_cycles: assert property (p_ctrl_two_cycles) else $error("control op did not stall once");

  property p_extra_cycle;
    exec && ind_msb && !dec_ctrl && !dec_soft_rst |=> s_one_stall;
  endproperty
  a_extra_cycle: assert property (p_extra_cycle) else $error("indirect high access missed extra cycle");

  property p_rel_jump;
    exec && dec_rel_jump |=> pc_out == $past(pc_inc) + $past(sext9);
  endproperty
  a_rel_jump: assert property (p_rel_jump) else $error("relative jump target wrong");

  property p_call;
    exec && dec_call |=> pc_out == {$past(pclath_in[6:3]), $past(instr_in[10:0])} && top_of_stack == $past(pc_inc);
  endproperty
  a_call: assert property (p_call) else $error("call target or pushed address wrong");

  property p_ret_lit;
    exec && dec_ret_lit |=> pc_out == $past(top_of_stack) && w_out == $past(instr_in[7:0]);
  endproperty
  a_ret_lit: assert property (p_ret_lit) else $error("literal return wrong");

  sequence s_wdt_pulse;
    watchdog_clear_out && timeout_flag_out && powerdown_flag_out ##1 (watchdog_clear_out == $past(exec && dec_wdt));
  endsequence

  property p_wdt;
    exec && dec_wdt |=> s_wdt_pulse;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog clear effects wrong");

  property p_standby;
    exec && dec_standby |=> standby_out && timeout_flag_out && !powerdown_flag_out && instr_ready_out;
  endproperty
  a_standby: assert property (p_standby) else $error("standby entry wrong");

  property p_idle;
    exec && dec_idle |=> pc_out == $past(pc_inc) && $stable(w_out) && instr_ready_out;
  endproperty
  a_idle: assert property (p_idle) else $error("idle op changed state");

  property p_option;
    exec && dec_option |=> option_out == $past(w_out);
  endproperty
  a_option: assert property (p_option) else $error("option load wrong");

  property p_ptr_add;
    exec && dec_ptr_add && !sel_n |=> file_pointer0_out == $past(ptr_add_res) && $stable(zero_out);
  endproperty
  a_ptr_add: assert property (p_ptr_add) else $error("pointer add wrong");

  property p_lit_add;
    exec && dec_lit_add |=> carry_out == $past(add_sum[8]) && digit_carry_flag_out == $past(add_low[4]);
  endproperty
  a_lit_add: assert property (p_lit_add) else $error("literal add flags wrong");

  property p_lit_and;
    exec && dec_lit_and |=> w_out == ($past(w_out) & $past(instr_in[7:0]))
      && zero_out == (w_out == 8'h00) && $stable(carry_out);
  endproperty
  a_lit_and: assert property (p_lit_and) else $error("literal and zero flag wrong");
endmodule : isd_core

// ===== src/isd_pkg.sv
// Purpose: shared constants for the instruction set decoder and executor
// Assumes: 14-bit instruction words, 8-bit data, 16-bit file pointers
// Notes: opcodes are held as mask/value pairs; a word matches when (word & mask) == value
//
// Function
// - jumps, calls and returns take two cycles, second one idle.
// - indirect window access with file pointer MSB set adds one cycle.
// - relative_jump 11 001k.. with 9-bit offset; jump_by_w_offset 0x000B; two cycles.
// - call 10 0k.., absolute_jump 10 1k.., subroutine_invoke_by_w 0x000A; two cycles.
// - interrupt_return 0x0009, return 0x0008, return_with_literal 11 0100..; two cycles.
// - watchdog_clear_op 0x0064, one cycle, clears watchdog, sets timeout and powerdown flags.
// - 0x0063 enters standby in one cycle, updating timeout and powerdown flags.
// - 0x0000 is idle_op, 0x0001 is software device reset; one cycle each.
// - 0x0062 copies W into the prescale option register in one cycle.
// - 0x0060-0x0067, except 0x0062-0x0064, copies W into the pin_direction_reg picked by low three bits.
// - pointer_add_literal 11 0001 0nkk kkkk, n picks pointer, one cycle, no flags.
// - pointer_add_literal sign-extends 6-bit literal and adds to full 16-bit pointer.
// - file pointer arithmetic wraps modulo 16 bits.
// - pointer_load 0x0010-0x0017 reads via pointer into W, mode update, sets zero.
// - indexed pointer_load 11 1111 0nkk kkkk reads pointer plus index into W, zero.
// - pointer_store 0x0018-0x001F writes W via pointer with mode update, no flags.
// - indexed pointer_store 11 1111 1nkk kkkk writes W at pointer plus index.
// - literal_and ANDs W with 8-bit literal into W, zero flag only.
// - literal_add adds 8-bit literal to W, updates carry, digit carry and zero.
// - and_with_file ANDs W with file 0-127, destination bit picks W or file.
package isd_pkg;
  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int INSTR_W = 14;
  localparam int PC_W = 15;
  localparam int DATA_W = 8;
  localparam int FP_W = 16;
  localparam int STACK_DEPTH_DEF = 16;
  localparam int PIN_DIR_REGS = 8;

  // ----------------------------------------------------------------
  // opcode masks and values
  // ----------------------------------------------------------------
  localparam logic [13:0] MASK_FULL = 14'h3FFF;
  localparam logic [13:0] MASK_TOP5 = 14'h3E00;
  localparam logic [13:0] MASK_TOP3 = 14'h3800;
  localparam logic [13:0] MASK_TOP6 = 14'h3F00;
  localparam logic [13:0] MASK_TOP7 = 14'h3F80;
  localparam logic [13:0] MASK_LOW3 = 14'h3FF8;
  localparam logic [13:0] OP_REL_JUMP = 14'h3200;
  localparam logic [13:0] OP_JUMP_BY_W = 14'h000B;
  localparam logic [13:0] OP_CALL = 14'h2000;
  localparam logic [13:0] OP_ABS_JUMP = 14'h2800;
  localparam logic [13:0] OP_CALL_BY_W = 14'h000A;
  localparam logic [13:0] OP_INT_RETURN = 14'h0009;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_RET_LIT = 14'h3400;
  localparam logic [13:0] OP_WDT_CLEAR = 14'h0064;
  localparam logic [13:0] OP_IDLE = 14'h0000;
  localparam logic [13:0] OP_OPTION_LOAD = 14'h0062;
  localparam logic [13:0] OP_SOFT_RESET = 14'h0001;
  localparam logic [13:0] OP_STANDBY = 14'h0063;
  localparam logic [13:0] OP_PIN_DIR = 14'h0060;
  localparam logic [13:0] OP_PTR_ADD = 14'h3100;
  localparam logic [13:0] OP_PTR_LOAD = 14'h0010;
  localparam logic [13:0] OP_PTR_STORE = 14'h0018;
  localparam logic [13:0] OP_PTR_LOAD_IDX = 14'h3F00;
  localparam logic [13:0] OP_PTR_STORE_IDX = 14'h3F80;
  localparam logic [13:0] OP_LIT_AND = 14'h3900;
  localparam logic [13:0] OP_LIT_ADD = 14'h3E00;
  localparam logic [13:0] OP_AND_FILE = 14'h0500;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_N_IMM = 6;
  localparam int POS_N_MODE = 2;
  localparam int POS_DEST = 7;
  localparam logic [6:0] ADDR_IND_WIN0 = 7'h00;
  localparam logic [6:0] ADDR_IND_WIN1 = 7'h01;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] PIN_DIR_RST = 8'hFF;
  localparam logic TIMEOUT_RST = 1'b1;
  localparam logic POWERDOWN_RST = 1'b1;

  // pointer_update_mode codes
  localparam logic [1:0] UPD_PRE_INC = 2'h0;
  localparam logic [1:0] UPD_PRE_DEC = 2'h1;
  localparam logic [1:0] UPD_POST_INC = 2'h2;
  localparam logic [1:0] UPD_POST_DEC = 2'h3;

  // execution phase
  typedef enum logic [1:0] {PH_EXEC, PH_FLUSH, PH_EXTRA} isd_phase_t;
endpackage : isd_pkg
